/* File: ifhc_consts.svh */
`ifndef IFHC_CONSTS_SVH
`define IFHC_CONSTS_SVH
// register addresses on the 4-bit register select
`define IFHC_ADDR_PORT_B_OUT 4'h0
`define IFHC_ADDR_PORT_A_OUT 4'h1
`define IFHC_ADDR_T1_LOW 4'h4
`define IFHC_ADDR_T1_HIGH 4'h5
`define IFHC_ADDR_T2_LOW 4'h8
`define IFHC_ADDR_T2_HIGH 4'h9
`define IFHC_ADDR_SHIFTER 4'ha
`define IFHC_ADDR_CONFIG 4'hc
`define IFHC_ADDR_FLAGS 4'hd
`define IFHC_ADDR_ENABLE 4'he
// flag bit positions
`define IFHC_BIT_CA_CTL 0
`define IFHC_BIT_CA_STB 1
`define IFHC_BIT_SHIFT 2
`define IFHC_BIT_CB_CTL 3
`define IFHC_BIT_CB_STB 4
`define IFHC_BIT_T2 5
`define IFHC_BIT_T1 6
`define IFHC_BIT_IRQ 7
// control_line_config fields
`define IFHC_CFG_A_EDGE 0
`define IFHC_CFG_A_MODE_LO 1
`define IFHC_CFG_B_EDGE 4
`define IFHC_CFG_B_MODE_LO 5
// reset values
`define IFHC_RST_FLAGS 7'h00
`define IFHC_RST_ENABLE 7'h00
`define IFHC_RST_CONFIG 8'h00
`endif

/* File: ifhc_pkg.sv */
package ifhc_pkg;
  // control line mode encodings
  typedef enum logic [2:0] {
    IFHC_IN_NEG = 3'h0,
    IFHC_IN_NEG_IND = 3'h1,
    IFHC_IN_POS = 3'h2,
    IFHC_IN_POS_IND = 3'h3,
    IFHC_OUT_HAND = 3'h4,
    IFHC_OUT_PULSE = 3'h5,
    IFHC_OUT_LOW = 3'h6,
    IFHC_OUT_HIGH = 3'h7
  } ifhc_mode_e;
endpackage : ifhc_pkg

/* File: ifhc_line_if.sv */
`timescale 1ns/1ps
interface ifhc_line_if;
  logic [2:0] mode;
  logic strobe_edge;
  logic ctl_pin;
  logic strobe_pin;
  logic access;
  logic ctl_event;
  logic strobe_event;
  logic clear_ok;
  logic drive_level;
  logic drive_en;
  modport ctrl (output mode, strobe_edge, ctl_pin, strobe_pin, access,
    input ctl_event, strobe_event, clear_ok, drive_level, drive_en);
  modport line (input mode, strobe_edge, ctl_pin, strobe_pin, access,
    output ctl_event, strobe_event, clear_ok, drive_level, drive_en);
endinterface : ifhc_line_if

/* File: ifhc_line.sv */
`timescale 1ns/1ps
`include "ifhc_consts.svh"
module ifhc_line (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  ifhc_line_if.line lif
);
  logic strobe_prev_r;
  logic ctl_prev_r;
  logic level_r;
  logic level_nxt;
  logic strobe_hit;
  logic is_output;

  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic rising);
    edge_hit = rising ? (!prev && cur) : (prev && !cur);
  endfunction : edge_hit

  assign strobe_hit = edge_hit(strobe_prev_r, lif.strobe_pin,
                               lif.strobe_edge);
  assign is_output = lif.mode[2];
  assign lif.strobe_event = strobe_hit;
  // bit 1 of the mode picks the control-line edge in the input modes
  assign lif.ctl_event = !is_output &&
    edge_hit(ctl_prev_r, lif.ctl_pin, lif.mode[1]);
  assign lif.clear_ok = !lif.mode[0] || is_output;
  // next level goes out so the top's pin flop shows it one edge after access
  assign lif.drive_level = level_nxt;
  assign lif.drive_en = is_output;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      strobe_prev_r <= 1'b0;
      ctl_prev_r <= 1'b0;
    end else begin
      strobe_prev_r <= lif.strobe_pin;
      ctl_prev_r <= lif.ctl_pin;
    end
  end

  always_comb begin
    level_nxt = level_r;
    case (ifhc_pkg::ifhc_mode_e'(lif.mode))
      ifhc_pkg::IFHC_OUT_HAND: begin
        if (lif.access) begin
          level_nxt = 1'b0;
        end else if (strobe_hit) begin
          level_nxt = 1'b1;
        end
      end
      ifhc_pkg::IFHC_OUT_PULSE: level_nxt = !lif.access;
      ifhc_pkg::IFHC_OUT_LOW: level_nxt = 1'b0;
      ifhc_pkg::IFHC_OUT_HIGH: level_nxt = 1'b1;
      default: level_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      level_r <= 1'b1;
    end else begin
      level_r <= level_nxt;
    end
  end
endmodule : ifhc_line

/* File: ifhc_irq_ctrl.sv */
`timescale 1ns/1ps
`include "ifhc_consts.svh"
// ==========================================================
// Overview of operation
// [R1] flag bit 7 reads OR of each flag ANDed with its enable
// [R2] flags 0,1 set by port-A line edges, cleared by port-A output access
// [R3] flag 2 set on eight shifts done, cleared by shifter access
// [R4] flags 3,4 set by port-B line edges, cleared by port-B output access
// [R5] flag 5 set on second timer timeout, cleared by low read/high write
// [R6] flag 6 set on first timer timeout, cleared by low read/high write
// [R7] bit 7 is no flag; writing one leaves it, drops with enabled flags
// [R8] enable write with bit 7 zero clears bits where data is one
// [R9] enable write with bit 7 one sets bits where data is one
// [R10] enable read returns seven enables, bit 7 zero
// [R11] config bit 0 picks port-A strobe edge, 0 falling, 1 rising
// [R12] port-A modes 000/010 input, falling/rising, cleared by output access
// [R13] port-A independent modes ignore output access; clear by flag write
// [R14] port-A mode 100 low on output access, high on strobe edge
// [R15] port-A mode 101 low one cycle after output access
// [R16] port-A modes 110/111 hold line low/high
// [R17] config bit 4 picks port-B strobe edge, cleared by output access
// [R18] port-B strobe flag still set when shifter uses that pin
// [R19] port-B control modes only apply with serial port disabled
// [R20] port-B independent modes: output access does not clear flag
// [R21] port-B mode 100 low only on output write, high on strobe edge
// [R22] port-B mode 101 pulses low after write; 110/111 hold low/high
// [R23] interrupt request pulled low while any enabled flag is set
// [R24] flag write clears each flag whose data bit is one
// [R25] reset clears flags and enables, releasing interrupt request
module ifhc_irq_ctrl (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic reg_sel_in_en,
  input wire logic [3:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic shift_done_in,
  input wire logic serial_enabled_in,
  input wire logic first_timer_timeout_in,
  input wire logic second_timer_timeout_in,
  input wire logic port_a_strobe_in,
  input wire logic port_a_control_line_in,
  input wire logic port_b_strobe_line_in,
  input wire logic port_b_control_line_in,
  output logic [7:0] reg_rdata_out,
  output logic irq_n_out,
  output logic irq_oe_out,
  output logic port_a_control_line_out,
  output logic port_a_control_line_oe_out,
  output logic port_b_control_line_out,
  output logic port_b_control_line_oe_out
);
  // ==========================================================
  // registers and decode
  logic [6:0] interrupt_flags_r;
  logic [6:0] interrupt_flags_nxt;
  logic [6:0] interrupt_enable_mask_r;
  logic [6:0] interrupt_enable_mask_nxt;
  logic [7:0] control_line_config_r;
  logic [6:0] set_ev;
  logic [6:0] clr_ev;
  logic irq_any;
  logic acc;
  logic rd;
  logic wr;
  logic acc_a;
  logic acc_b;
  logic wr_b;

  function automatic logic hit(input logic [3:0] addr,
                               input logic [3:0] want);
    hit = (addr == want);
  endfunction : hit

  assign acc = reg_sel_in_en;
  assign rd = acc && !reg_write_in;
  assign wr = acc && reg_write_in;
  assign acc_a = acc && hit(reg_addr_in, `IFHC_ADDR_PORT_A_OUT);
  assign acc_b = acc && hit(reg_addr_in, `IFHC_ADDR_PORT_B_OUT);
  assign wr_b = wr && hit(reg_addr_in, `IFHC_ADDR_PORT_B_OUT);

  // ==========================================================
  // control lines
  ifhc_line_if a_if ();
  ifhc_line_if b_if ();

  assign a_if.mode = control_line_config_r[`IFHC_CFG_A_MODE_LO +: 3];
  assign a_if.strobe_edge = control_line_config_r[`IFHC_CFG_A_EDGE]; // R11
  assign a_if.ctl_pin = port_a_control_line_in;
  assign a_if.strobe_pin = port_a_strobe_in;
  assign a_if.access = acc_a; // R14 R15
  // serial port takes the line over while enabled
  assign b_if.mode = serial_enabled_in ? 3'h0 :
    control_line_config_r[`IFHC_CFG_B_MODE_LO +: 3]; // R19
  assign b_if.strobe_edge = control_line_config_r[`IFHC_CFG_B_EDGE]; // R17
  // edge history keeps tracking the pin, so no false edge when serial ends
  assign b_if.ctl_pin = port_b_control_line_in;
  assign b_if.strobe_pin = port_b_strobe_line_in; // R18
  assign b_if.access = wr_b; // R21 R22

  ifhc_line u_line_a (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .lif(a_if.line)
  );

  ifhc_line u_line_b (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .lif(b_if.line)
  );

  // ==========================================================
  // flag set and clear events
  always_comb begin
    set_ev = 7'h00;
    set_ev[`IFHC_BIT_CA_CTL] = a_if.ctl_event; // R2 R12
    set_ev[`IFHC_BIT_CA_STB] = a_if.strobe_event; // R2
    set_ev[`IFHC_BIT_SHIFT] = shift_done_in; // R3
    set_ev[`IFHC_BIT_CB_CTL] = b_if.ctl_event && !serial_enabled_in; // R4 R19
    set_ev[`IFHC_BIT_CB_STB] = b_if.strobe_event; // R4 R18
    set_ev[`IFHC_BIT_T2] = second_timer_timeout_in; // R5
    set_ev[`IFHC_BIT_T1] = first_timer_timeout_in; // R6
  end

  always_comb begin
    clr_ev = 7'h00;
    if (wr && hit(reg_addr_in, `IFHC_ADDR_FLAGS)) begin
      clr_ev = reg_wdata_in[6:0]; // R24 R13 R7
    end
    clr_ev[`IFHC_BIT_CA_CTL] = clr_ev[`IFHC_BIT_CA_CTL] ||
      (acc_a && a_if.clear_ok); // R12 R13
    clr_ev[`IFHC_BIT_CA_STB] = clr_ev[`IFHC_BIT_CA_STB] || acc_a; // R2
    clr_ev[`IFHC_BIT_SHIFT] = clr_ev[`IFHC_BIT_SHIFT] ||
      (acc && hit(reg_addr_in, `IFHC_ADDR_SHIFTER)); // R3
    clr_ev[`IFHC_BIT_CB_CTL] = clr_ev[`IFHC_BIT_CB_CTL] ||
      (acc_b && b_if.clear_ok); // R4 R20
    clr_ev[`IFHC_BIT_CB_STB] = clr_ev[`IFHC_BIT_CB_STB] || acc_b; // R17
    clr_ev[`IFHC_BIT_T2] = clr_ev[`IFHC_BIT_T2] ||
      (rd && hit(reg_addr_in, `IFHC_ADDR_T2_LOW)) ||
      (wr && hit(reg_addr_in, `IFHC_ADDR_T2_HIGH)); // R5
    clr_ev[`IFHC_BIT_T1] = clr_ev[`IFHC_BIT_T1] ||
      (rd && hit(reg_addr_in, `IFHC_ADDR_T1_LOW)) ||
      (wr && hit(reg_addr_in, `IFHC_ADDR_T1_HIGH)); // R6
  end

  // set wins over a clear in the same cycle
  assign interrupt_flags_nxt = (interrupt_flags_r & ~clr_ev) | set_ev;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      interrupt_flags_r <= `IFHC_RST_FLAGS; // R25
    end else begin
      interrupt_flags_r <= interrupt_flags_nxt;
    end
  end

  // ==========================================================
  // enable mask and config
  always_comb begin
    interrupt_enable_mask_nxt = interrupt_enable_mask_r;
    if (wr && hit(reg_addr_in, `IFHC_ADDR_ENABLE)) begin
      if (reg_wdata_in[7]) begin
        interrupt_enable_mask_nxt = interrupt_enable_mask_r |
          reg_wdata_in[6:0]; // R9
      end else begin
        interrupt_enable_mask_nxt = interrupt_enable_mask_r &
          ~reg_wdata_in[6:0]; // R8
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      interrupt_enable_mask_r <= `IFHC_RST_ENABLE; // R25
    end else begin
      interrupt_enable_mask_r <= interrupt_enable_mask_nxt;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      control_line_config_r <= `IFHC_RST_CONFIG;
    end else if (wr && hit(reg_addr_in, `IFHC_ADDR_CONFIG)) begin
      control_line_config_r <= reg_wdata_in;
    end
  end

  // ==========================================================
  // interrupt request and read data
  // next flags and next enables, so the pin agrees with bit 7 once updated
  assign irq_any = |(interrupt_flags_nxt & interrupt_enable_mask_nxt); // R1 R7

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      irq_n_out <= 1'b0;
      irq_oe_out <= 1'b0;
    end else begin
      irq_n_out <= 1'b0;
      irq_oe_out <= irq_any; // R23
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (rd) begin
      case (reg_addr_in)
        `IFHC_ADDR_FLAGS: reg_rdata_out <=
          {|(interrupt_flags_r & interrupt_enable_mask_r),
           interrupt_flags_r}; // R1
        `IFHC_ADDR_ENABLE: reg_rdata_out <=
          {1'b0, interrupt_enable_mask_r}; // R10
        `IFHC_ADDR_CONFIG: reg_rdata_out <= control_line_config_r;
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // pin drivers
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      port_a_control_line_out <= 1'b1;
      port_a_control_line_oe_out <= 1'b0;
      port_b_control_line_out <= 1'b1;
      port_b_control_line_oe_out <= 1'b0;
    end else begin
      port_a_control_line_out <= a_if.drive_level; // R14 R15 R16
      port_a_control_line_oe_out <= a_if.drive_en;
      port_b_control_line_out <= b_if.drive_level; // R21 R22
      port_b_control_line_oe_out <= b_if.drive_en && !serial_enabled_in;
    end
  end
endmodule : ifhc_irq_ctrl

/* File: ifhc_irq_ctrl_checker.sv */
`timescale 1ns/1ps
`include "ifhc_consts.svh"
module ifhc_irq_ctrl_checker (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic reg_sel_in_en,
  input wire logic [3:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic serial_enabled_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic irq_n_out,
  input wire logic irq_oe_out,
  input wire logic port_a_control_line_out,
  input wire logic port_a_control_line_oe_out,
  input wire logic port_b_control_line_out,
  input wire logic port_b_control_line_oe_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // ==========================================================
  // config shadow
  logic [7:0] cfg_r;
  wire logic wr = reg_sel_in_en && reg_write_in;
  wire logic rd = reg_sel_in_en && !reg_write_in;
  wire logic acc_a = reg_sel_in_en && reg_addr_in == `IFHC_ADDR_PORT_A_OUT;
  wire logic rd_b = rd && reg_addr_in == `IFHC_ADDR_PORT_B_OUT;
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) cfg_r <= 8'h00;
    else if (wr && reg_addr_in == `IFHC_ADDR_CONFIG) cfg_r <= reg_wdata_in;
  end
  // ==========================================================
  // assertions
  a_flag_irq_bit: assert property (rd && reg_addr_in == `IFHC_ADDR_FLAGS
    |=> reg_rdata_out[7] == $past(irq_oe_out)) else $error("irq bit wrong");
  a_enable_msb_zero: assert property (rd && reg_addr_in == `IFHC_ADDR_ENABLE
    |=> !reg_rdata_out[7]) else $error("enable bit 7 not zero");
  a_irq_open_drain: assert property (irq_n_out == 1'b0)
    else $error("irq data not low");
  a_enable_clear_all: assert property (wr && reg_wdata_in == 8'h7f
    && reg_addr_in == `IFHC_ADDR_ENABLE |=> !irq_oe_out)
    else $error("irq after disable all");
  a_reset_release: assert property ($fell(sys_rst_in) |-> !irq_oe_out
    && !port_a_control_line_oe_out && !port_b_control_line_oe_out)
    else $error("outputs active after reset");
  a_pulse_a_low: assert property (cfg_r[3:1] == 3'h5 && acc_a
    |=> port_a_control_line_oe_out && !port_a_control_line_out)
    else $error("pulse a not low");
  a_pulse_a_end: assert property (cfg_r[3:1] == 3'h5 && acc_a ##1
    (cfg_r[3:1] == 3'h5 && !acc_a) |=> port_a_control_line_out)
    else $error("pulse a too long");
  a_manual_a_low: assert property ((cfg_r[3:1] == 3'h6)[*3]
    |-> port_a_control_line_oe_out && !port_a_control_line_out)
    else $error("manual a not low");
  a_input_a_float: assert property ((!cfg_r[3])[*3]
    |-> !port_a_control_line_oe_out) else $error("a driven in input mode");
  a_hand_b_read: assert property (cfg_r[7:5] == 3'h4 && !serial_enabled_in
    && rd_b && port_b_control_line_out |=> port_b_control_line_out)
    else $error("b lowered by read");
  a_manual_b_high: assert property ((!serial_enabled_in
    && cfg_r[7:5] == 3'h7)[*3] |-> port_b_control_line_oe_out
    && port_b_control_line_out) else $error("manual b not high");
  a_serial_b_free: assert property ((serial_enabled_in)[*3]
    |-> !port_b_control_line_oe_out) else $error("b driven with serial on");
  c_irq_rise: cover property ($rose(irq_oe_out));
  c_pulse_a: cover property (cfg_r[3:1] == 3'h5 && acc_a);
  c_hand_b: cover property (cfg_r[7:5] == 3'h4 && rd_b);
endmodule : ifhc_irq_ctrl_checker
bind ifhc_irq_ctrl ifhc_irq_ctrl_checker u_chk (.clock_in(clock_in),
  .sys_rst_in(sys_rst_in), .reg_sel_in_en(reg_sel_in_en),
  .reg_addr_in(reg_addr_in), .reg_write_in(reg_write_in),
  .reg_wdata_in(reg_wdata_in), .serial_enabled_in(serial_enabled_in),
  .reg_rdata_out(reg_rdata_out), .irq_n_out(irq_n_out),
  .irq_oe_out(irq_oe_out), .port_a_control_line_out(port_a_control_line_out),
  .port_a_control_line_oe_out(port_a_control_line_oe_out),
  .port_b_control_line_out(port_b_control_line_out),
  .port_b_control_line_oe_out(port_b_control_line_oe_out));

/* File: ifhc_periph.sv */
`timescale 1ns/1ps
// peripheral: drives strobes and idle control lines, acks port-A handshakes
module ifhc_periph (
  input wire logic clock_in,
  input wire logic ack_en_in,
  input wire logic [3:0] want_in,
  input wire logic a_out_in,
  input wire logic a_oe_in,
  input wire logic b_out_in,
  input wire logic b_oe_in,
  output logic [3:0] pin_out
);
  // ack follows the data-ready line two cycles late
  logic [1:0] ack_r = 2'b11;
  always_ff @(posedge clock_in) begin
    ack_r <= {ack_r[0], a_out_in};
  end
  // bits: a strobe, a control, b strobe, b control
  assign pin_out[0] = ack_en_in ? ack_r[1] : want_in[0];
  assign pin_out[1] = a_oe_in ? a_out_in : want_in[1];
  assign pin_out[2] = want_in[2];
  assign pin_out[3] = b_oe_in ? b_out_in : want_in[3];
endmodule : ifhc_periph

/* File: ifhc_irq_ctrl_tb_top.sv */
`timescale 1ns/1ps
`include "ifhc_consts.svh"
module ifhc_irq_ctrl_tb_top;
  localparam logic [3:0] PA = `IFHC_ADDR_PORT_A_OUT;
  localparam logic [3:0] PB = `IFHC_ADDR_PORT_B_OUT;
  localparam logic [3:0] FL = `IFHC_ADDR_FLAGS;
  localparam logic [3:0] EN = `IFHC_ADDR_ENABLE;
  localparam logic [3:0] CF = `IFHC_ADDR_CONFIG;
  logic clock_in = 1'b0, sys_rst_in = 1'b1, sel = 1'b0, wr = 1'b0;
  logic [3:0] addr = 4'h0, want = 4'b1011;
  logic [7:0] wd = 8'h00, rdata;
  logic sh = 1'b0, ser = 1'b0, t1 = 1'b0, t2 = 1'b0, ack = 1'b0;
  logic irq_n, irq_oe, ao, aoe, bo, boe;
  logic [3:0] pin;
  int n_mismatch = 0, num_checks = 0;
  always #50 clock_in = ~clock_in;
  ifhc_irq_ctrl dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .reg_sel_in_en(sel), .reg_addr_in(addr), .reg_write_in(wr),
    .reg_wdata_in(wd), .shift_done_in(sh), .serial_enabled_in(ser),
    .first_timer_timeout_in(t1), .second_timer_timeout_in(t2),
    .port_a_strobe_in(pin[0]), .port_a_control_line_in(pin[1]),
    .port_b_strobe_line_in(pin[2]), .port_b_control_line_in(pin[3]),
    .reg_rdata_out(rdata), .irq_n_out(irq_n), .irq_oe_out(irq_oe),
    .port_a_control_line_out(ao), .port_a_control_line_oe_out(aoe),
    .port_b_control_line_out(bo), .port_b_control_line_oe_out(boe));
  ifhc_periph u_per (.clock_in(clock_in), .ack_en_in(ack), .want_in(want),
    .a_out_in(ao), .a_oe_in(aoe), .b_out_in(bo), .b_oe_in(boe),
    .pin_out(pin));
  // ==========================================================
  // helpers
  task automatic tick(input int n);
    sel = 1'b0;
    repeat (n) @(negedge clock_in);
  endtask : tick
  task automatic check(input string nm, input logic [7:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic acc(input logic [3:0] a, input logic w, input logic [7:0] d);
    // strobe stays up across back-to-back accesses; tick drops it
    sel = 1'b1; addr = a; wr = w; wd = d;
    @(negedge clock_in);
  endtask : acc
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    acc(a, 1'b0, 8'h00);
    check("read", rdata, e);
  endtask : rd
  task automatic pin_set(input int i, input logic v);
    want[i] = v;
    tick(3);
  endtask : pin_set
  task automatic lines(input logic [1:0] ea, eb);
    check("lines", {4'h0, aoe, ao, boe, bo}, {4'h0, ea, eb});
  endtask : lines
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd(FL, 8'h00); rd(EN, 8'h00); rd(CF, 8'h00);
    check("irq", {7'h0, irq_oe}, 8'h00); lines(2'b01, 2'b01);
    $display("reset test done");
  endtask : t_reset
  task automatic t_enable();
    acc(EN, 1, 8'h85); acc(EN, 1, 8'h01);
    rd(EN, 8'h04);
    acc(EN, 1, 8'h7f); rd(EN, 8'h00);
    $display("enable test done");
  endtask : t_enable
  task automatic t_a_flags();
    pin_set(0, 0); rd(FL, 8'h02);
    acc(EN, 1, 8'h82); check("irq", {7'h0, irq_oe}, 8'h01);
    rd(FL, 8'h82); acc(FL, 1, 8'h80); rd(FL, 8'h82);
    acc(PA, 0, 8'h00); rd(FL, 8'h00);
    acc(CF, 1, 8'h01); pin_set(0, 1); rd(FL, 8'h82);
    acc(FL, 1, 8'h02); pin_set(0, 0); rd(FL, 8'h00);
    acc(EN, 1, 8'h02);
    $display("port a flag test done");
  endtask : t_a_flags
  task automatic t_a_ctl();
    acc(CF, 1, 8'h02); pin_set(1, 0); rd(FL, 8'h01);
    acc(PA, 1, 8'h00); rd(FL, 8'h01);
    acc(FL, 1, 8'h01); rd(FL, 8'h00);
    acc(CF, 1, 8'h00); pin_set(1, 1); rd(FL, 8'h00);
    pin_set(1, 0); acc(PA, 0, 8'h00); rd(FL, 8'h00);
    acc(CF, 1, 8'h04); pin_set(1, 1); rd(FL, 8'h01);
    acc(PA, 0, 8'h00); rd(FL, 8'h00);
    $display("port a control test done");
  endtask : t_a_ctl
  task automatic t_b_flags();
    acc(CF, 1, 8'h10); pin_set(2, 1); pin_set(3, 0);
    rd(FL, 8'h18); acc(PB, 0, 8'h00); rd(FL, 8'h00);
    acc(CF, 1, 8'h30); pin_set(3, 1); pin_set(3, 0);
    acc(PB, 1, 8'h00); rd(FL, 8'h08); acc(FL, 1, 8'h08);
    ser = 1'b1; pin_set(2, 0); pin_set(2, 1); rd(FL, 8'h10);
    acc(PB, 0, 8'h00); rd(FL, 8'h00); ser = 1'b0;
    $display("port b flag test done");
  endtask : t_b_flags
  task automatic t_events();
    sh = 1; tick(1); sh = 0; tick(2); rd(FL, 8'h04);
    acc(`IFHC_ADDR_SHIFTER, 1, 8'h00); rd(FL, 8'h00);
    t2 = 1; tick(1); t2 = 0; tick(2); rd(FL, 8'h20);
    acc(`IFHC_ADDR_T2_LOW, 0, 8'h00); rd(FL, 8'h00);
    t2 = 1; tick(1); t2 = 0; acc(`IFHC_ADDR_T2_HIGH, 1, 8'h00);
    rd(FL, 8'h00);
    t1 = 1; tick(1); t1 = 0; tick(2); rd(FL, 8'h40);
    acc(`IFHC_ADDR_T1_LOW, 0, 8'h00); rd(FL, 8'h00);
    t1 = 1; tick(1); t1 = 0; acc(`IFHC_ADDR_T1_HIGH, 1, 8'h00);
    rd(FL, 8'h00);
    $display("event test done");
  endtask : t_events
  task automatic t_a_out();
    acc(CF, 1, 8'h0a); acc(PA, 0, 8'h00); lines(2'b10, 2'b01);
    tick(1); lines(2'b11, 2'b01);
    acc(CF, 1, 8'h0c); tick(2); lines(2'b10, 2'b01);
    acc(CF, 1, 8'h0e); tick(2); lines(2'b11, 2'b01);
    ack = 1; acc(CF, 1, 8'h08); rd(CF, 8'h08); tick(2);
    acc(PA, 1, 8'h00); lines(2'b10, 2'b01);
    tick(5); lines(2'b11, 2'b01);
    ack = 0; tick(3); acc(FL, 1, 8'h7f);
    $display("port a output test done");
  endtask : t_a_out
  task automatic t_b_out();
    acc(CF, 1, 8'h8e); tick(2); acc(PB, 0, 8'h00); lines(2'b11, 2'b11);
    acc(PB, 1, 8'h00); lines(2'b11, 2'b10);
    pin_set(2, 0); lines(2'b11, 2'b11);
    acc(CF, 1, 8'hae); acc(PB, 1, 8'h00); lines(2'b11, 2'b10);
    tick(1); lines(2'b11, 2'b11);
    acc(CF, 1, 8'hce); tick(2); lines(2'b11, 2'b10);
    acc(CF, 1, 8'hee); tick(3); lines(2'b11, 2'b11);
    ser = 1; tick(3); check("b oe", {7'h0, boe}, 8'h00); ser = 0;
    $display("port b output test done");
  endtask : t_b_out
  initial begin
    tick(2);
    sys_rst_in = 1'b0;
    t_reset(); t_enable(); t_a_flags(); t_a_ctl();
    t_b_flags(); t_events(); t_a_out(); t_b_out();
    stop_test();
  end
  initial begin
    repeat (3000) @(posedge clock_in);
    n_mismatch++;
    $display("watchdog expired");
    stop_test();
  end
endmodule : ifhc_irq_ctrl_tb_top
